/* File: uxc_defines.vh */
// constants for the extended command decoder
`ifndef UXC_DEFINES_VH
`define UXC_DEFINES_VH
// register byte addresses on the wishbone slave
`define UXC_ADR_CMD      4'h0
`define UXC_ADR_STATUS   4'h4
`define UXC_ADR_IRQ_STAT 4'h8
`define UXC_ADR_IRQ_MASK 4'hc
// command field
`define UXC_CMD_W        5
`define UXC_CODE_RESUME  5'h16
`define UXC_CODE_PAUSE   5'h17
`define UXC_CODE_CANCEL  5'h18
`define UXC_CODE_ADRRST  5'h1b
`define UXC_CODE_ERRRD   5'h1d
`define UXC_CODE_CHIPRST 5'h1f
`define UXC_CODE_ERRENT  5'h0d
// status register bit positions
`define UXC_ST_PAUSED    0
`define UXC_ST_FC_PEND   1
`define UXC_ST_ERR_ENTRY 2
`define UXC_ST_ADR_FLAG  3
`define UXC_ST_TX_BUSY   4
// interrupt bit positions
`define UXC_IRQ_W        3
`define UXC_IRQ_ADR      0
`define UXC_IRQ_IGNORED  1
`define UXC_IRQ_CHIPRST  2
// chip reset pulse length in cycles
`define UXC_RST_CYCLES   4'h4
`endif

/* File: uxc_tx_gate.v */
// transmit start gate: pause, resume and flow-control priority
`default_nettype none
`include "uxc_defines.vh"
module uxc_tx_gate (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pause_i,
  input  wire resume_i,
  input  wire queue_has_char_i,
  input  wire fc_pending_i,
  input  wire shift_busy_i,
  output wire paused_o,
  output wire load_data_o,
  output wire load_fc_o
);
  reg paused_r;

  // pause flag; a resume overrides a same-cycle pause
  always @(posedge clk_i) begin
    if (rst_i) begin
      paused_r <= 1'b0;
    end else if (resume_i) begin
      paused_r <= 1'b0; // RULE2
    end else if (pause_i) begin
      paused_r <= 1'b1; // RULE4
    end
  end

  assign paused_o    = paused_r;
  // flow control goes first and ignores the pause
  assign load_fc_o   = !shift_busy_i && fc_pending_i; // RULE6
  // a busy shifter finishes; only new starts are held
  assign load_data_o = !shift_busy_i && !fc_pending_i && queue_has_char_i && !paused_r; // RULE4 RULE5
endmodule // uxc_tx_gate
`default_nettype wire

/* File: uxc_wb_slave.v */
// classic wishbone slave handshake, one wait state
`default_nettype none
module uxc_wb_slave (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       cyc_i,
  input  wire       stb_i,
  input  wire       we_i,
  output reg        ack_o,
  output wire       wr_o,
  output wire       rd_o
);
  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // a write lands at the edge where the master sees ack high
  assign wr_o = cyc_i && stb_i && ack_o && we_i;
  assign rd_o = cyc_i && stb_i && ack_o && !we_i;
endmodule // uxc_wb_slave
`default_nettype wire

/* File: uxc_ext_cmd.v */
// extended command decoder for the uart channel
// Overview of operation
// (RULE1) five-bit command in bits 4..0, acted on when written
// (RULE2) resume clears host pause; transmitter then loads next queued char
// (RULE3) resume is ignored while automatic transmit mode is on
// (RULE4) pause code stops transmitter starting further characters
// (RULE5) character already in shift register finishes through stop bit
// (RULE6) flow-control characters requested by receiver still sent while paused
// (RULE7) cancel code drops pending host flow-control char not yet loaded
// (RULE8) cancel with nothing pending or already started does nothing
// (RULE9) address reset code clears address-recognised interrupt status
// (RULE10) read-time code restores error accumulation on queue read
// (RULE11) entry-time code accumulates break, framing, parity on queue entry
// (RULE12) all-ones code performs a chip-wide reset; the code acts on it only when CHANNEL_A is set
// (RULE13) chip reset on channel a equals the hardware reset pin
// (RULE14) reserved codes take no action, change no state
// (RULE15) host pauses after flow-off interrupt, resumes later with resume code
`default_nettype none
`include "uxc_defines.vh"
module uxc_ext_cmd #(
  parameter CHANNEL_A = 1'b1
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output wire        ack_o,
  output reg         int_o,
  input  wire        auto_tx_i,
  input  wire        queue_has_char_i,
  input  wire        host_fc_req_i,
  input  wire        shift_busy_i,
  input  wire        adr_recognised_i,
  output reg         load_data_o,
  output reg         load_fc_o,
  output reg         fc_from_host_o,
  output reg         err_on_entry_o,
  output reg         chip_rst_o
);
  wire       wr;
  wire       paused;
  wire       g_load_data;
  wire       g_load_fc;
  wire [4:0] code;
  wire       cmd_wr;
  reg        host_fc_r;
  reg        adr_flag_r;
  reg  [`UXC_IRQ_W-1:0] irq_stat_r;
  reg  [`UXC_IRQ_W-1:0] irq_mask_r;
  reg  [`UXC_IRQ_W-1:0] irq_set;
  reg  [3:0] rst_cnt_r;
  reg        hit_resume;
  reg        hit_pause;
  reg        hit_cancel;
  reg        hit_adrrst;
  reg        hit_reserved;
  wire       soft_rst;

  // bus handshake
  uxc_wb_slave u_bus (
    .clk_i (clk_i),
    .rst_i (soft_rst),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i  (we_i),
    .ack_o (ack_o),
    .wr_o  (wr),
    .rd_o  ()
  );

  // chip reset acts like the pin while the pulse runs
  assign soft_rst = rst_i || (rst_cnt_r != 4'h0); // RULE13

  // command write: low lane of the command register
  assign cmd_wr = wr && (adr_i == `UXC_ADR_CMD) && sel_i[0]; // RULE1
  assign code   = dat_i[`UXC_CMD_W-1:0]; // RULE1

  // decode written code into one-cycle strobes
  always @* begin
    hit_resume   = 1'b0;
    hit_pause    = 1'b0;
    hit_cancel   = 1'b0;
    hit_adrrst   = 1'b0;
    hit_reserved = 1'b0;
    if (cmd_wr) begin
      case (code)
        `UXC_CODE_RESUME: hit_resume = !auto_tx_i; // RULE2 RULE3
        `UXC_CODE_PAUSE:  hit_pause  = 1'b1; // RULE4
        `UXC_CODE_CANCEL: hit_cancel = 1'b1; // RULE7
        `UXC_CODE_ADRRST: hit_adrrst = 1'b1; // RULE9
        `UXC_CODE_ERRRD, `UXC_CODE_ERRENT, `UXC_CODE_CHIPRST: hit_reserved = 1'b0;
        5'h19, 5'h1a, 5'h1c, 5'h1e: hit_reserved = 1'b1; // RULE14
        default: hit_reserved = 1'b0;
      endcase
    end
  end

  // pause and start arbitration
  uxc_tx_gate u_gate (
    .clk_i            (clk_i),
    .rst_i            (soft_rst),
    .pause_i          (hit_pause),
    .resume_i         (hit_resume),
    .queue_has_char_i (queue_has_char_i),
    .fc_pending_i     (host_fc_r),
    .shift_busy_i     (shift_busy_i),
    .paused_o         (paused),
    .load_data_o      (g_load_data),
    .load_fc_o        (g_load_fc)
  );

  // host flow-control char pending; cancel only before load
  always @(posedge clk_i) begin
    if (soft_rst) begin
      host_fc_r <= 1'b0;
    end else if (host_fc_req_i) begin
      host_fc_r <= 1'b1; // new request wins over cancel
    end else if (g_load_fc) begin
      host_fc_r <= 1'b0; // now in shifter, sent in full  RULE8
    end else if (hit_cancel) begin
      host_fc_r <= 1'b0; // RULE7 RULE8
    end
  end

  // error accumulation mode
  always @(posedge clk_i) begin
    if (soft_rst) begin
      err_on_entry_o <= 1'b0;
    end else if (cmd_wr && code == `UXC_CODE_ERRENT) begin
      err_on_entry_o <= 1'b1; // RULE11
    end else if (cmd_wr && code == `UXC_CODE_ERRRD) begin
      err_on_entry_o <= 1'b0; // RULE10
    end else if (hit_reserved) begin
      err_on_entry_o <= err_on_entry_o; // RULE14
    end
  end

  // address-recognised status; a new event beats the clear
  always @(posedge clk_i) begin
    if (soft_rst) begin
      adr_flag_r <= 1'b0;
    end else if (adr_recognised_i) begin
      adr_flag_r <= 1'b1;
    end else if (hit_adrrst) begin
      adr_flag_r <= 1'b0; // RULE9
    end
  end

  // chip reset pulse counter, held off the soft reset itself
  always @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt_r <= 4'h0;
    end else if (rst_cnt_r != 4'h0) begin
      rst_cnt_r <= rst_cnt_r - 4'h1;
    end else if (cmd_wr && code == `UXC_CODE_CHIPRST && CHANNEL_A) begin
      rst_cnt_r <= `UXC_RST_CYCLES; // RULE12 RULE13
    end
  end

  // interrupt events
  always @* begin
    irq_set = {`UXC_IRQ_W{1'b0}};
    irq_set[`UXC_IRQ_ADR]     = adr_recognised_i;
    irq_set[`UXC_IRQ_IGNORED] = cmd_wr && code == `UXC_CODE_RESUME && auto_tx_i;
    irq_set[`UXC_IRQ_CHIPRST] = 1'b0;
  end

  // sticky status, write one to clear, set wins; mask register
  always @(posedge clk_i) begin
    if (soft_rst) begin
      irq_stat_r <= {`UXC_IRQ_W{1'b0}};
      irq_mask_r <= {`UXC_IRQ_W{1'b0}};
    end else begin
      if (wr && adr_i == `UXC_ADR_IRQ_STAT && sel_i[0]) begin
        irq_stat_r <= (irq_stat_r & ~dat_i[`UXC_IRQ_W-1:0]) | irq_set;
      end else if (hit_adrrst) begin
        irq_stat_r <= (irq_stat_r & ~(3'h1 << `UXC_IRQ_ADR)) | irq_set; // RULE9
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      if (wr && adr_i == `UXC_ADR_IRQ_MASK && sel_i[0]) begin
        irq_mask_r <= dat_i[`UXC_IRQ_W-1:0];
      end
    end
  end

  // registered outputs; pin reset and chip reset clear them alike, except chip_rst_o, which both set
  always @(posedge clk_i) begin
    if (soft_rst) begin
      int_o          <= 1'b0;
      load_data_o    <= 1'b0;
      load_fc_o      <= 1'b0;
      fc_from_host_o <= 1'b0;
      chip_rst_o     <= 1'b1; // RULE13
    end else begin
      int_o          <= |(irq_stat_r & irq_mask_r);
      load_data_o    <= g_load_data; // RULE2 RULE5
      load_fc_o      <= g_load_fc; // RULE6
      fc_from_host_o <= host_fc_r;
      chip_rst_o     <= 1'b0;
    end
  end

  // read data, latched on the request cycle
  always @(posedge clk_i) begin
    if (soft_rst) begin
      dat_o <= 32'h0; // RULE13
    end else if (cyc_i && stb_i && !we_i) begin
      if (adr_i == `UXC_ADR_STATUS) begin
        dat_o <= {27'h0, shift_busy_i, adr_flag_r, err_on_entry_o, host_fc_r, paused};
      end else if (adr_i == `UXC_ADR_IRQ_STAT) begin
        dat_o <= {29'h0, irq_stat_r};
      end else if (adr_i == `UXC_ADR_IRQ_MASK) begin
        dat_o <= {29'h0, irq_mask_r};
      end else begin
        dat_o <= 32'h0; // command register and unmapped read zero
      end
    end
  end
endmodule // uxc_ext_cmd
`default_nettype wire

/* File: uxc_ext_cmd_properties.sv */
// port assertions for the extended command decoder
`default_nettype none
module uxc_ext_cmd_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        auto_tx_i,
  input wire logic        queue_has_char_i,
  input wire logic        host_fc_req_i,
  input wire logic        shift_busy_i,
  input wire logic        load_data_o,
  input wire logic        load_fc_o,
  input wire logic        fc_from_host_o,
  input wire logic        err_on_entry_o,
  input wire logic        chip_rst_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // open request, command write and its code
  wire       t = cyc_i && stb_i && !ack_o;
  wire       w = cyc_i && stb_i && ack_o && we_i && adr_i == 4'h0 && sel_i[0];
  wire [4:0] c = dat_i[4:0];
  logic      p_r;
  // pause as commanded; resume does not count in automatic mode
  always_ff @(posedge clk_i)
    if (rst_i || chip_rst_o) p_r <= 1'b0;
    else if (w && c == 5'h17) p_r <= 1'b1;
    else if (w && c == 5'h16 && !auto_tx_i) p_r <= 1'b0;
  chk_ack_once: assert property (t && !chip_rst_o && !(w && c == 5'h1f) |=> ack_o ##1 !ack_o)
    else $error("ack missing or long");
  chk_pause_hold: assert property (p_r |=> !load_data_o)
    else $error("data load while paused");
  chk_resume_load: assert property (
    !p_r && !w && !chip_rst_o && queue_has_char_i && !shift_busy_i && !fc_from_host_o && !$past(host_fc_req_i)
    |-> ##[1:2] load_data_o)
    else $error("queued char not loaded");
  chk_fc_paused: assert property (fc_from_host_o && !shift_busy_i && !$past(w && c == 5'h18) |-> ##[1:2] load_fc_o)
    else $error("flow char not loaded");
  chk_cancel_drop: assert property (w && c == 5'h18 && shift_busy_i && !host_fc_req_i |-> ##2 !fc_from_host_o)
    else $error("cancel kept flow char");
  chk_err_read: assert property (w && c == 5'h1d |=> !err_on_entry_o)
    else $error("read mode not set");
  chk_err_entry: assert property (w && c == 5'h0d |=> err_on_entry_o)
    else $error("entry mode not set");
  chk_chip_reset: assert property (w && c == 5'h1f |-> ##[1:3] chip_rst_o)
    else $error("no chip reset");
  chk_reserved_quiet: assert property (
    w && c inside {5'h19, 5'h1a, 5'h1c, 5'h1e} && !host_fc_req_i |=> $stable(err_on_entry_o) && !$rose(fc_from_host_o))
    else $error("reserved code changed state");
  cover property (p_r && load_fc_o);
  cover property (w && c == 5'h18 && fc_from_host_o);
  cover property (w && c == 5'h1f);
endmodule // uxc_ext_cmd_chk
bind uxc_ext_cmd uxc_ext_cmd_chk i_uxc_ext_cmd_chk (.*);
`default_nettype wire

/* File: uxc_host_model.sv */
// host processor model: classic wishbone master
`default_nettype none
module uxc_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  input  wire logic        stop_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [3:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  logic hung;
  // bus idle at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 4'h0;
    sel_o = 4'hf;
    dat_o = 32'h0;
    hung = 1'b0;
  end
  // one single cycle, held until ack, chip reset or 64 cycles
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack_i && !stop_i && n < 64);
    q = rdat_i;
    hung = n >= 64;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule // uxc_host_model
`default_nettype wire

/* File: tb_uxc_ext_cmd.sv */
// self-checking bench for the extended command decoder
`default_nettype none
module tb_uxc_ext_cmd;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, int_o, auto_tx_i, queue_has_char_i, host_fc_req_i;
  logic        shift_busy_i, adr_recognised_i, load_data_o, load_fc_o, fc_from_host_o, err_on_entry_o, chip_rst_o;
  logic [3:0]  adr_i, sel_i, cnt_r;
  logic [31:0] dat_i, dat_o;
  logic [4:0]  rsv [4] = '{5'h19, 5'h1a, 5'h1c, 5'h1e};
  int          errors, checked, n_data, n_fc;
  uxc_ext_cmd i_uxc_ext_cmd (.*);
  uxc_host_model i_uxc_host_model (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o), .stop_i(chip_rst_o),
    .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // stand-in shifter, busy from a load until its stop bit is out
  assign shift_busy_i = load_data_o || load_fc_o || cnt_r != 4'h0;
  always @(posedge clk_i) begin
    cnt_r <= rst_i ? 4'h0 : (load_data_o || load_fc_o) ? 4'hf : cnt_r - {3'h0, cnt_r != 4'h0};
    n_data <= n_data + int'(load_data_o === 1'b1);
    n_fc <= n_fc + int'(load_fc_o === 1'b1);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xf(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    i_uxc_host_model.xfer(w, a, d, q);
    if (i_uxc_host_model.hung) begin
      errors++;
      close_out;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xf(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    xf(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // one-cycle pulse on the flow request or the address flag
  task automatic pulse(input logic fc);
    @(posedge clk_i);
    host_fc_req_i <= fc;
    adr_recognised_i <= !fc;
    @(posedge clk_i);
    host_fc_req_i <= 1'b0;
    adr_recognised_i <= 1'b0;
  endtask
  // main sequence
  initial begin
    {rst_i, auto_tx_i, queue_has_char_i, host_fc_req_i, adr_recognised_i} = 5'h10;
    {errors, checked, n_data, n_fc} = '0;
    tick(2);
    rst_i <= 1'b0;
    tick(3);
    wr(4'h0, 32'h0000_00ed);
    tick(1);
    chk(err_on_entry_o, 1'b1);
    wr(4'h0, 32'h1d);
    tick(1);
    chk(err_on_entry_o, 1'b0);
    wr(4'h0, 32'h17);
    queue_has_char_i <= 1'b1;
    pulse(1'b1);
    tick(20);
    chk(n_data, 0);
    chk(n_fc, 1);
    auto_tx_i <= 1'b1;
    wr(4'h0, 32'h16);
    tick(20);
    chk(n_data, 0);
    auto_tx_i <= 1'b0;
    wr(4'h0, 32'h16);
    tick(3);
    chk(n_data, 1);
    queue_has_char_i <= 1'b0;
    pulse(1'b1);
    wr(4'h0, 32'h18);
    tick(2);
    chk(fc_from_host_o, 1'b0);
    tick(20);
    pulse(1'b1);
    tick(2);
    wr(4'h0, 32'h18);
    tick(20);
    chk(n_fc, 2);
    wr(4'hc, 32'h1);
    rd(4'h8, 32'h2);
    chk(int_o, 1'b0);
    pulse(1'b0);
    tick(2);
    chk(int_o, 1'b1);
    wr(4'h0, 32'h1b);
    tick(2);
    chk(int_o, 1'b0);
    rd(4'h8, 32'h2);
    wr(4'h8, 32'h2);
    rd(4'h8, 32'h0);
    rd(4'h6, 32'h0);
    wr(4'h0, 32'h0d);
    foreach (rsv[i]) begin
      wr(4'h0, {27'h0, rsv[i]});
      rd(4'h4, 32'h4);
    end
    wr(4'h0, 32'h17);
    wr(4'h0, 32'h1f);
    for (int n = 0; n < 8 && chip_rst_o !== 1'b1; n++) @(posedge clk_i);
    chk(chip_rst_o, 1'b1);
    tick(8);
    rd(4'h4, 32'h0);
    close_out;
  end
endmodule // tb_uxc_ext_cmd
`default_nettype wire
